// ==== bench/hub_event_model.sv ====
// Model of the hub-side detection logic that issues one-cycle event strobes.
module hub_event_model (
	// Strobe requests from the bench, one bit per event.
	input wire logic [4:0] ev_i,
	// Event strobes toward the status block.
	output logic hub_parity_err_o,
	output logic pci_parity_err_o,
	output logic master_abort_rcvd_o,
	output logic target_abort_rcvd_o,
	output logic target_abort_sig_o
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb begin
		hub_parity_err_o = ev_i[0];
		pci_parity_err_o = ev_i[1];
		master_abort_rcvd_o = ev_i[2];
		target_abort_rcvd_o = ev_i[3];
		target_abort_sig_o = ev_i[4];
	end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the primary status block over APB.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] S = pstat_pkg::PRIMARY_STATUS_ADDR;
	localparam logic [7:0] C = pstat_pkg::COMMAND_ADDR;
	localparam logic [7:0] M = pstat_pkg::IRQ_MASK_ADDR;
	logic ref_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, err, nmi_o, health_o, irq_o;
	logic [4:0] ev = 5'h00;
	logic hp, pp, ma, ta, ts;
	int n_errors = 0, tests_run = 0, n_health = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	hub_event_model i_ev (.ev_i(ev), .hub_parity_err_o(hp), .pci_parity_err_o(pp),
		.master_abort_rcvd_o(ma), .target_abort_rcvd_o(ta), .target_abort_sig_o(ts));
	primary_status_block i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.hub_parity_err_i(hp), .pci_parity_err_i(pp), .master_abort_rcvd_i(ma),
		.target_abort_rcvd_i(ta), .target_abort_sig_i(ts), .nmi_o(nmi_o),
		.system_health_logic_o(health_o), .irq_o(irq_o));
	always @(posedge ref_clk_i) begin
		if (health_o === 1'b1) n_health++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; event strobes ride on the access cycle.
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [4:0] e);
		int k;
		k = 0;
		@(posedge ref_clk_i);
		psel_i <= 1;
		pwrite_i <= we;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1;
		ev <= e;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (k >= 20) n_errors++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		ev <= 5'h00;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0, 5'h00);
		chk(rd, exp);
	endtask
	task automatic conclude();
		$display("errors %0d, comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 0;
		rchk(S, 32'h80);
		rchk(C, 32'h1);
		rchk(M, 32'h0);
		xfer(1, S, 32'hFFFF, 5'h00);
		rchk(S, 32'h80);
		xfer(0, M, 32'h0, 5'h03);
		rchk(S, 32'h8080);
		xfer(1, S, 32'h0, 5'h00);
		rchk(S, 32'h8080);
		xfer(1, S, 32'h8000, 5'h00);
		rchk(S, 32'h80);
		xfer(1, C, 32'h0140, 5'h00);
		rchk(C, 32'h140);
		xfer(1, M, 32'h1000, 5'h00);
		xfer(0, M, 32'h0, 5'h1F);
		rchk(S, 32'hF980);
		chk(nmi_o, 1);
		chk(irq_o, 1);
		chk(n_health, 1);
		xfer(1, S, 32'h1000, 5'h00);
		rchk(S, 32'hE980);
		chk(irq_o, 0);
		xfer(1, S, 32'h2000, 5'h04);
		rchk(S, 32'hE980);
		xfer(1, S, 32'h4000, 5'h00);
		rchk(S, 32'hA980);
		chk(nmi_o, 0);
		xfer(0, 8'h40, 32'h0, 5'h00);
		chk(rd, 0);
		chk(err, 1);
		rst_i <= 1;
		@(posedge ref_clk_i);
		rst_i <= 0;
		rchk(S, 32'h80);
		conclude();
	end
endmodule

// ==== src/primary_status_block.sv ====
// Primary status register bank of a hub-to-PCI bridge with APB access and interrupt.
// Contract
// - Writing one clears flag; zero leaves it.
// - Hub parity error always sets bit 15.
// - PCI addr/cmd/special parity sets 14 if enabled.
// - Bit 14 with error enable raises NMI.
// - Received hub master abort sets bit 13.
// - Received hub target abort sets bit 12.
// - Bit 12 setting reported to health logic.
// - Signalled hub target abort sets bit 11.
// - Bits 10:9 read-only fast timing zero.
// - Hub parity with response enable sets 8.
// - Bit 7 read-only, always one.
// - Bits 6, 5 zero; 4:0 reserved.
// - Command bit 6 gates hub parity reporting.
//
// Added by the designer: the APB register port.
module primary_status_block (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [pstat_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Event strobes from detection logic, one cycle each.
	input wire logic hub_parity_err_i,
	input wire logic pci_parity_err_i,
	input wire logic master_abort_rcvd_i,
	input wire logic target_abort_rcvd_i,
	input wire logic target_abort_sig_i,
	// System outputs.
	output logic nmi_o,
	output logic system_health_logic_o,
	output logic irq_o
);
	logic [15:0] command_r;
	logic [15:0] irq_mask_r;
	logic [15:0] status;
	logic [pstat_pkg::FLAG_N-1:0] set_vec;
	logic [pstat_pkg::FLAG_N-1:0] clr_vec;
	logic [pstat_pkg::FLAG_N-1:0] flag_vec;
	logic [15:0] wc_bits;
	logic wr_en;
	logic rd_en;
	logic hit_status;
	logic hit_cmd;
	logic hit_mask;
	logic ta_rcvd_d_r;
	logic par_resp_en;
	logic sys_err_en;

	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && penable_i && !pwrite_i;
	assign hit_status = paddr_i == pstat_pkg::PRIMARY_STATUS_ADDR;
	assign hit_cmd = paddr_i == pstat_pkg::COMMAND_ADDR;
	assign hit_mask = paddr_i == pstat_pkg::IRQ_MASK_ADDR;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !(hit_status || hit_cmd || hit_mask);

	assign par_resp_en = command_r[pstat_pkg::BIT_PAR_RESP_EN];
	assign sys_err_en = command_r[pstat_pkg::BIT_SYS_ERR_EN];

	// Vector index 4 down to 0 maps to status bits 15, 14, 13, 12 and 11.
	// The reported parity flag on bit 8 sits apart below, as it has its own gate.
	assign set_vec[4] = hub_parity_err_i;
	assign set_vec[3] = pci_parity_err_i && par_resp_en;
	assign set_vec[2] = master_abort_rcvd_i;
	assign set_vec[1] = target_abort_rcvd_i;
	assign set_vec[0] = target_abort_sig_i;

	assign wc_bits = (wr_en && hit_status) ? (pwdata_i[15:0] & pstat_pkg::STATUS_WC_MASK)
		: 16'h0000;
	assign clr_vec = {wc_bits[pstat_pkg::BIT_HUB_PARITY], wc_bits[pstat_pkg::BIT_SYS_ERR],
		wc_bits[pstat_pkg::BIT_MA_RCVD], wc_bits[pstat_pkg::BIT_TA_RCVD],
		wc_bits[pstat_pkg::BIT_TA_SIG]};

	// The flag vectors are wired to five fixed status bits, so no other count can serve.
	generate
		if (pstat_pkg::FLAG_N != 5) begin : g_bad_flag_n
			$error("flag count must be five");
		end
		if (pstat_pkg::ADDR_W < 8) begin : g_bad_addr_w
			$error("address must hold the highest byte address");
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < pstat_pkg::FLAG_N; gi++) begin : g_flag
			wc_flag u_flag (
				.ref_clk_i(ref_clk_i),
				.rst_i(rst_i),
				.set_i(set_vec[gi]),
				.clr_i(clr_vec[gi]),
				.flag_o(flag_vec[gi])
			);
		end
	endgenerate

	logic reported_parity_flag;
	wc_flag u_rep_parity (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.set_i(hub_parity_err_i && par_resp_en),
		.clr_i(wc_bits[pstat_pkg::BIT_REP_PARITY]),
		.flag_o(reported_parity_flag)
	);

	always_comb begin
		status = pstat_pkg::PRIMARY_STATUS_RST;
		status[pstat_pkg::BIT_HUB_PARITY] = flag_vec[4];
		status[pstat_pkg::BIT_SYS_ERR] = flag_vec[3];
		status[pstat_pkg::BIT_MA_RCVD] = flag_vec[2];
		status[pstat_pkg::BIT_TA_RCVD] = flag_vec[1];
		status[pstat_pkg::BIT_TA_SIG] = flag_vec[0];
		status[10:9] = pstat_pkg::SEL_TIMING_FAST;
		status[pstat_pkg::BIT_REP_PARITY] = reported_parity_flag;
		status[pstat_pkg::BIT_FAST_B2B] = 1'b1;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			command_r <= pstat_pkg::COMMAND_RST;
		end else if (wr_en && hit_cmd) begin
			command_r <= pwdata_i[15:0] & pstat_pkg::COMMAND_WMASK;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_mask_r <= pstat_pkg::IRQ_MASK_RST;
		end else if (wr_en && hit_mask) begin
			irq_mask_r <= pwdata_i[15:0] & pstat_pkg::STATUS_WC_MASK;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			if (hit_status) begin
				prdata_o <= {16'h0000, status};
			end else if (hit_cmd) begin
				prdata_o <= {16'h0000, command_r};
			end else if (hit_mask) begin
				prdata_o <= {16'h0000, irq_mask_r};
			end else begin
				prdata_o <= 32'h0000_0000;
			end
		end
	end

	// Pulse to the health logic on the rising edge of the received target abort flag.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ta_rcvd_d_r <= 1'b0;
		end else begin
			ta_rcvd_d_r <= flag_vec[1];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			system_health_logic_o <= 1'b0;
		end else begin
			system_health_logic_o <= flag_vec[1] && !ta_rcvd_d_r;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nmi_o <= 1'b0;
		end else begin
			nmi_o <= flag_vec[3] && sys_err_en;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & irq_mask_r & pstat_pkg::STATUS_WC_MASK);
		end
	end

	a_hub_parity_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		hub_parity_err_i |=> status[15]) else $error("bit 15 not set");
	a_pci_parity_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pci_parity_err_i && !par_resp_en && !status[14] && !wr_en) |=> !status[14])
		else $error("bit 14 set while disabled");
	a_nmi_raise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pci_parity_err_i && par_resp_en && sys_err_en && !wr_en) |=> ##1 nmi_o)
		else $error("nmi missing");
	a_master_abort_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		master_abort_rcvd_i |=> status[13]) else $error("bit 13 not set");
	a_target_abort_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		target_abort_rcvd_i |=> status[12]) else $error("bit 12 not set");
	a_health_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(status[12]) |=> system_health_logic_o ##1 !system_health_logic_o)
		else $error("health pulse wrong");
	a_sig_abort_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		target_abort_sig_i |=> status[11]) else $error("bit 11 not set");
	a_fixed_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status[10:0] == {2'h0, status[8], 8'h80}) else $error("fixed bits wrong");
	a_rep_parity_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(hub_parity_err_i && par_resp_en) |=> status[8])
		else $error("bit 8 not set");
	a_rep_parity_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(hub_parity_err_i && !par_resp_en && !status[8]) |=> !status[8])
		else $error("bit 8 set while disabled");
	a_read_only_ones: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status[7] && !status[6] && !status[5]) else $error("capability bits");
	a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status[4:0] == 5'h00) else $error("reserved bits not zero");
	a_wc_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_en && hit_status && pwdata_i[13] && !master_abort_rcvd_i) |=> !status[13])
		else $error("write one did not clear");

	// A zero written over a set flag must leave it standing.
	a_zero_keeps: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_en && hit_status && !pwdata_i[12]) |=> status[12] == $past(status[12])
		|| $past(target_abort_rcvd_i)) else $error("zero write changed flag");
	a_pci_parity_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pci_parity_err_i && par_resp_en) |=> status[14]) else $error("bit 14 not set");
	// The error output is a level that follows bit 14 and the enable by one cycle.
	a_nmi_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> nmi_o == $past(status[14] && sys_err_en)) else $error("nmi level wrong");
	// The health pulse may only appear one cycle after bit 12 went from zero to one.
	a_health_only_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		system_health_logic_o |-> $past(status[12]) && !$past(status[12], 2))
		else $error("health pulse without rise");
	a_sel_timing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status[10:9] == pstat_pkg::SEL_TIMING_FAST) else $error("timing field not fast");
	// Read data of the status register carries the fixed bits and a zero upper half.
	a_status_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(psel_i && !penable_i && !pwrite_i && hit_status)
		|=> prdata_o == {16'h0000, $past(status)}) else $error("status read wrong");
	a_cmd_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_en && hit_cmd) |=> command_r == $past(pwdata_i[15:0] & pstat_pkg::COMMAND_WMASK))
		else $error("command write wrong");
	// Mapped addresses never raise the bus error.
	a_mapped_no_err: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(psel_i && penable_i && (hit_status || hit_cmd || hit_mask)) |-> !pslverr_o)
		else $error("bus error on mapped address");
	// The interrupt is a level of the masked status, one cycle behind it.
	a_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> irq_o == $past(|(status & irq_mask_r))) else $error("interrupt level wrong");
endmodule

// ==== src/pstat_pkg.sv ====
// Package with register map, field positions and reset values of the primary status block.
package pstat_pkg;
	localparam int ADDR_W = 8;
	localparam int FLAG_N = 5;
	// Printed offset 0x06 is not a multiple of four, so it is kept as an index.
	localparam logic [ADDR_W-1:0] PRIMARY_STATUS_IDX = 8'h06;
	localparam logic [ADDR_W-1:0] COMMAND_IDX = 8'h04;
	localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 8'h20;
	localparam logic [ADDR_W-1:0] PRIMARY_STATUS_ADDR = 8'h18;
	localparam logic [ADDR_W-1:0] COMMAND_ADDR = 8'h10;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h80;
	localparam logic [15:0] PRIMARY_STATUS_RST = 16'h0080;
	localparam logic [15:0] COMMAND_RST = 16'h0001;
	localparam logic [15:0] COMMAND_WMASK = 16'h0147;
	localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
	localparam logic [15:0] STATUS_WC_MASK = 16'hF900;
	localparam int BIT_HUB_PARITY = 15;
	localparam int BIT_SYS_ERR = 14;
	localparam int BIT_MA_RCVD = 13;
	localparam int BIT_TA_RCVD = 12;
	localparam int BIT_TA_SIG = 11;
	localparam int BIT_REP_PARITY = 8;
	localparam int BIT_FAST_B2B = 7;
	localparam int BIT_PAR_RESP_EN = 6;
	localparam int BIT_SYS_ERR_EN = 8;
	localparam logic [1:0] SEL_TIMING_FAST = 2'h0;
endpackage

// ==== src/wc_flag.sv ====
// One sticky write-one-to-clear flag where a set beats a same-cycle clear.
module wc_flag (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Set and clear strobes.
	input wire logic set_i,
	input wire logic clr_i,
	// Flag state.
	output logic flag_o
);
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end

	a_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		set_i |=> flag_o) else $error("flag lost its set");
	a_clear_works: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clr_i && !set_i) |=> !flag_o) else $error("flag not cleared");
	a_hold_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!clr_i && !set_i) |=> flag_o == $past(flag_o)) else $error("flag changed");
endmodule
